// *** hw/light_prox_map.vh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  light/proximity interrupt filter. Definitions only; included by bare name.
*/
`ifndef LIGHT_PROX_MAP_VH
`define LIGHT_PROX_MAP_VH

// Register offsets on the byte-wide register port
`define FILTER_COUNTS_ADDR   8'h0C
`define WAIT_EXT_ADDR        8'h0D
`define PULSE_TOTAL_ADDR     8'h0E

// Field positions
`define PROX_PERS_MSB        7
`define PROX_PERS_LSB        4
`define LIGHT_PERS_MSB       3
`define LIGHT_PERS_LSB       0
`define LONG_WAIT_BIT        1

// Reset values
`define FILTER_COUNTS_RST    8'h00
`define WAIT_EXT_RST         8'h00
`define PULSE_TOTAL_RST      8'h01

// Timing: clock 50 MHz, step 2.72 ms, pulse rate 62.5 kHz
`define CLK_HZ               50000000
`define STEP_US              2720
`define STEP_CYCLES          ((`CLK_HZ / 1000000) * `STEP_US)
`define PULSE_HZ             62500
`define PULSE_CYCLES         (`CLK_HZ / `PULSE_HZ)
`define LONG_WAIT_FACTOR     12

`endif

// *** hw/persistence_filter.v ***
/*
  One persistence filter: counts consecutive out-of-window results and flags
  a qualified event. Assumes one result strobe per measurement cycle.
*/
`timescale 1ns/100ps
module persistence_filter #(
  parameter DATA_W = 16,
  parameter CNT_W  = 6
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // Result and window
  input  wire              result_valid,
  input  wire [DATA_W-1:0] result,
  input  wire [DATA_W-1:0] low_threshold,
  input  wire [DATA_W-1:0] high_threshold,
  // Required run length; zero means every cycle
  input  wire [CNT_W-1:0]  required_run,
  // Qualified event
  output reg               event_pulse
);

  reg  [CNT_W-1:0] run_count;
  wire             out_window;
  wire [CNT_W-1:0] next_run;

  assign out_window = (result < low_threshold) || (result > high_threshold);
  // Saturates so a very long run never wraps back below the required count
  assign next_run   = (run_count == {CNT_W{1'b1}}) ? run_count : run_count + {{(CNT_W-1){1'b0}}, 1'b1};

  // Run counter clears on any in-window result
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_count   <= {CNT_W{1'b0}};
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= 1'b0;
      if (result_valid) begin
        if (!out_window) begin
          run_count <= {CNT_W{1'b0}};
        end else begin
          run_count <= next_run;
        end
        if (required_run == {CNT_W{1'b0}}) begin
          event_pulse <= 1'b1;
        end else if (out_window && next_run >= required_run) begin
          event_pulse <= 1'b1;
        end
      end
    end
  end

endmodule // persistence_filter

// *** hw/light_prox_interrupt_filter.v ***
/*
  Interrupt persistence filtering, wait extension and emitter pulse train
  sequencing for a light/proximity sensor. Registers are written and read
  over a simple byte port decoded from the two-wire bus outside; results,
  thresholds, masks and enables arrive from neighbouring synchronous logic.
  Reserved config bits are stored as written; keeping them zero is host duty.
*/
`timescale 1ns/100ps
`include "light_prox_map.vh"
module light_prox_interrupt_filter #(
  parameter STEP_CYCLES  = `STEP_CYCLES,
  parameter PULSE_CYCLES = `PULSE_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_write,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Settings from neighbouring registers
  input  wire        power_on,
  input  wire        light_enable,
  input  wire        prox_enable,
  input  wire        wait_enable,
  input  wire        prox_irq_mask,
  input  wire        light_irq_mask,
  input  wire [7:0]  light_integration_setting,
  input  wire [7:0]  wait_period_setting,
  input  wire        irq_clear,
  // Results and thresholds
  input  wire        light_result_valid,
  input  wire [15:0] light_ch0_count,
  input  wire [15:0] light_low_threshold,
  input  wire [15:0] light_high_threshold,
  input  wire        prox_result_valid,
  input  wire [15:0] prox_count,
  input  wire [15:0] prox_low_threshold,
  input  wire [15:0] prox_high_threshold,
  // Sequencer outputs
  output reg         light_integrating,
  output reg         prox_cycle_active,
  output reg         emitter_pulse,
  output reg         waiting,
  // Interrupt state
  output reg         prox_irq,
  output reg         light_irq,
  output reg         irq_out
);

  // Sequencer states, one-hot
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_LIGHT = 4'b0010;
  localparam [3:0] ST_PROX  = 4'b0100;
  localparam [3:0] ST_WAIT  = 4'b1000;

  // Terminal counts held at 32 bits so every compare keeps full width
  localparam [31:0] STEP_LAST  = STEP_CYCLES - 1;
  localparam [31:0] PULSE_LAST = PULSE_CYCLES - 1;
  localparam [31:0] LONG_LAST  = `LONG_WAIT_FACTOR - 1;

  // Programmed registers, sequencer state and timers
  reg  [7:0]  interrupt_filter_counts;
  reg  [7:0]  wait_extension_config;
  reg  [7:0]  emitter_pulse_total;
  reg  [3:0]  state;
  reg  [31:0] step_timer;
  reg  [8:0]  step_count;
  reg  [3:0]  long_count;
  reg  [15:0] pulse_timer;
  reg  [7:0]  pulses_sent;
  reg  [5:0]  light_required;

  // Decoded fields and derived strobes
  wire        step_tick;
  wire        prox_event;
  wire        light_event;
  wire [3:0]  prox_filter_count;
  wire [3:0]  light_filter_count;
  wire        long_wait_select;
  wire [8:0]  light_last_step;
  wire [8:0]  wait_last_step;
  wire        pulse_due;
  wire        long_step_done;

  assign prox_filter_count  = interrupt_filter_counts[`PROX_PERS_MSB:`PROX_PERS_LSB];
  assign light_filter_count = interrupt_filter_counts[`LIGHT_PERS_MSB:`LIGHT_PERS_LSB];
  assign long_wait_select   = wait_extension_config[`LONG_WAIT_BIT];
  assign step_tick          = (step_timer == STEP_LAST);

  // Last step index of a period: 256-N steps counted up from zero
  assign light_last_step = 9'h0ff - {1'b0, light_integration_setting};
  assign wait_last_step  = 9'h0ff - {1'b0, wait_period_setting};
  // Pulse spacing, and the twelvefold prescale of long waits
  assign pulse_due       = ({16'h0000, pulse_timer} == PULSE_LAST);
  assign long_step_done  = !long_wait_select || ({28'h000_0000, long_count} == LONG_LAST);

  // Register writes; reserved config bits stored as written
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_filter_counts <= `FILTER_COUNTS_RST;
      wait_extension_config   <= `WAIT_EXT_RST;
      emitter_pulse_total     <= `PULSE_TOTAL_RST;
    end else if (reg_write) begin
      case (reg_addr)
        `FILTER_COUNTS_ADDR: interrupt_filter_counts <= reg_wdata;
        `WAIT_EXT_ADDR:      wait_extension_config   <= reg_wdata;
        `PULSE_TOTAL_ADDR:   emitter_pulse_total     <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux, registered; unmapped offsets read zero
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `FILTER_COUNTS_ADDR: reg_rdata <= interrupt_filter_counts;
        `WAIT_EXT_ADDR:      reg_rdata <= wait_extension_config;
        `PULSE_TOTAL_ADDR:   reg_rdata <= emitter_pulse_total;
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // Light code to run length: 1-3 direct, above that steps of five
  always @* begin
    if (light_filter_count <= 4'h3) begin
      light_required = {2'b00, light_filter_count};
    end else begin
      light_required = ({2'b00, light_filter_count} - 6'h03) * 6'h05;
    end
  end

  // Separate filters keep the two functions apart
  persistence_filter #(.DATA_W(16), .CNT_W(4)) u_prox_filter (
    .core_clk       (core_clk),
    .rst            (rst),
    .result_valid   (prox_result_valid),
    .result         (prox_count),
    .low_threshold  (prox_low_threshold),
    .high_threshold (prox_high_threshold),
    .required_run   (prox_filter_count),
    .event_pulse    (prox_event)
  );

  persistence_filter #(.DATA_W(16), .CNT_W(6)) u_light_filter (
    .core_clk       (core_clk),
    .rst            (rst),
    .result_valid   (light_result_valid),
    .result         (light_ch0_count),
    .low_threshold  (light_low_threshold),
    .high_threshold (light_high_threshold),
    .required_run   (light_required),
    .event_pulse    (light_event)
  );

  // Sticky interrupt flags; a new event beats a clear in the same cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prox_irq  <= 1'b0;
      light_irq <= 1'b0;
      irq_out   <= 1'b0;
    end else begin
      if (prox_event && prox_irq_mask) begin
        prox_irq <= 1'b1;
      end else if (irq_clear) begin
        prox_irq <= 1'b0;
      end
      if (light_event && light_irq_mask) begin
        light_irq <= 1'b1;
      end else if (irq_clear) begin
        light_irq <= 1'b0;
      end
      irq_out <= (prox_irq && prox_irq_mask) || (light_irq && light_irq_mask);
    end
  end

  // Step divider: one-cycle enable each 2.72 ms while in a timed state
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_timer <= 32'h0000_0000;
    end else if (state == ST_IDLE || state == ST_PROX || step_tick) begin
      step_timer <= 32'h0000_0000;
    end else begin
      step_timer <= step_timer + 32'h0000_0001;
    end
  end

  // Measurement sequencer: light period, prox burst, optional wait
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state             <= ST_IDLE;
      step_count        <= 9'h000;
      long_count        <= 4'h0;
      pulse_timer       <= 16'h0000;
      pulses_sent       <= 8'h00;
      light_integrating <= 1'b0;
      prox_cycle_active <= 1'b0;
      emitter_pulse     <= 1'b0;
      waiting           <= 1'b0;
    end else begin
      emitter_pulse <= 1'b0;
      if (!power_on) begin
        state             <= ST_IDLE;
        light_integrating <= 1'b0;
        prox_cycle_active <= 1'b0;
        waiting           <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (light_enable || prox_enable) begin
              state             <= ST_LIGHT;
              step_count        <= 9'h000;
              light_integrating <= light_enable;
            end
          end
          // Integration timer runs even with light off to pace prox
          ST_LIGHT: begin
            if (step_tick) begin
              if (step_count == light_last_step) begin
                light_integrating <= 1'b0;
                step_count        <= 9'h000;
                long_count        <= 4'h0;
                if (prox_enable) begin
                  state             <= ST_PROX;
                  prox_cycle_active <= 1'b1;
                  pulse_timer       <= 16'h0000;
                  pulses_sent       <= 8'h00;
                end else if (wait_enable) begin
                  state   <= ST_WAIT;
                  waiting <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                step_count <= step_count + 9'h001;
              end
            end
          end
          // Emit exactly the programmed count, one per pulse period
          // A count of zero leaves at once without pulsing
          ST_PROX: begin
            if (pulses_sent == emitter_pulse_total) begin
              prox_cycle_active <= 1'b0;
              if (wait_enable) begin
                state   <= ST_WAIT;
                waiting <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end else if (pulse_due) begin
              pulse_timer   <= 16'h0000;
              emitter_pulse <= 1'b1;
              pulses_sent   <= pulses_sent + 8'h01;
            end else begin
              pulse_timer <= pulse_timer + 16'h0001;
            end
          end
          // Wait steps, each stretched twelvefold in long mode
          ST_WAIT: begin
            if (step_tick) begin
              if (!long_step_done) begin
                long_count <= long_count + 4'h1;
              end else begin
                long_count <= 4'h0;
                if (step_count == wait_last_step) begin
                  waiting    <= 1'b0;
                  step_count <= 9'h000;
                  state      <= ST_IDLE;
                end else begin
                  step_count <= step_count + 9'h001;
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // light_prox_interrupt_filter

// *** verification/light_prox_checker_asserts.sv ***
/* Concurrent checks on the filter top ports.
   Assumes the bind below and one clock domain. */
`timescale 1ns/100ps
`include "light_prox_map.vh"
module light_prox_checker #(
  parameter STEP_CYCLES  = 10,
  parameter PULSE_CYCLES = 4
) (
  // Clock and reset
  input wire       core_clk,
  input wire       rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire       reg_write,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Settings and results
  input wire       power_on,
  input wire       prox_enable,
  input wire       prox_irq_mask,
  input wire       light_irq_mask,
  input wire       irq_clear,
  input wire       light_result_valid,
  input wire       prox_result_valid,
  // Watched outputs
  input wire       light_integrating,
  input wire       prox_cycle_active,
  input wire       emitter_pulse,
  input wire       prox_irq,
  input wire       light_irq,
  input wire       irq_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Flags rise only two cycles after their own strobe
  light_flag_cause_a: assert property ($rose(light_irq) |-> $past(light_result_valid, 2))
    else $error("light flag without light result");
  prox_flag_cause_a: assert property ($rose(prox_irq) |-> $past(prox_result_valid, 2))
    else $error("prox flag without prox result");
  irq_gating_a: assert property (irq_out == $past((prox_irq & prox_irq_mask) | (light_irq & light_irq_mask)))
    else $error("irq output differs from masked flags");
  // Clear loses only to an event landing at the same edge
  flag_clear_a: assert property (irq_clear && !$past(light_result_valid) |=> !light_irq)
    else $error("light flag survived clear");
  prox_clear_a: assert property (irq_clear && !$past(prox_result_valid) |=> !prox_irq)
    else $error("prox flag survived clear");
  pulse_spacing_a: assert property (emitter_pulse |=> !emitter_pulse [*3])
    else $error("emitter pulses too close");
  prox_after_light_a: assert property (power_on && prox_enable && $fell(light_integrating)
    |-> ##[0:2] prox_cycle_active)
    else $error("no prox cycle after integration");
  unmapped_read_a: assert property (!(reg_addr inside {[`FILTER_COUNTS_ADDR:`PULSE_TOTAL_ADDR]}) |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  write_readback_a: assert property (reg_write && reg_addr == `FILTER_COUNTS_ADDR ##1 reg_addr == `FILTER_COUNTS_ADDR
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("filter counts readback wrong");
endmodule // light_prox_checker

bind light_prox_interrupt_filter light_prox_checker #(.STEP_CYCLES(STEP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
  light_prox_checker_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_on(power_on), .prox_enable(prox_enable),
  .prox_irq_mask(prox_irq_mask), .light_irq_mask(light_irq_mask), .irq_clear(irq_clear),
  .light_result_valid(light_result_valid), .prox_result_valid(prox_result_valid),
  .light_integrating(light_integrating), .prox_cycle_active(prox_cycle_active), .emitter_pulse(emitter_pulse),
  .prox_irq(prox_irq), .light_irq(light_irq), .irq_out(irq_out));

// *** verification/host_model.sv ***
/* Host side of the byte register port.
   Assumes callers enter tasks between clock edges. */
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire       core_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic       reg_write,
  output logic [7:0] reg_wdata,
  input  wire  [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle strobe; data inverted after so stale bytes never match
  task write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = (a == 8'h0D) ? (d & 8'h02) : d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  // Read data lands one edge after the address
  task read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule // host_model

// *** verification/testbench.sv ***
/* Self-checking bench for the interrupt filter.
   Assumes shortened step and pulse counts of 10 and 4. */
`timescale 1ns/100ps
module testbench;
  logic        core_clk, rst, power_on, light_enable, prox_enable, wait_enable, irq_clear, reg_write;
  logic        prox_irq_mask, light_irq_mask, light_result_valid, prox_result_valid;
  logic [7:0]  light_integration_setting, wait_period_setting, rd;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] light_ch0_count, prox_count, low_thr, high_thr;
  wire         light_integrating, prox_cycle_active, emitter_pulse, waiting, prox_irq, light_irq, irq_out;
  int          mismatches, comparisons;
  logic [31:0] rnd;
  light_prox_interrupt_filter #(.STEP_CYCLES(10), .PULSE_CYCLES(4)) light_prox_interrupt_filter_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_on(power_on), .light_enable(light_enable), .prox_enable(prox_enable),
    .wait_enable(wait_enable), .prox_irq_mask(prox_irq_mask), .light_irq_mask(light_irq_mask),
    .light_integration_setting(light_integration_setting), .wait_period_setting(wait_period_setting),
    .irq_clear(irq_clear), .light_result_valid(light_result_valid), .light_ch0_count(light_ch0_count),
    .light_low_threshold(low_thr), .light_high_threshold(high_thr), .prox_result_valid(prox_result_valid),
    .prox_count(prox_count), .prox_low_threshold(low_thr), .prox_high_threshold(high_thr),
    .light_integrating(light_integrating), .prox_cycle_active(prox_cycle_active), .emitter_pulse(emitter_pulse),
    .waiting(waiting), .prox_irq(prox_irq), .light_irq(light_irq), .irq_out(irq_out));
  host_model host_model_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Required run length for a persistence code
  function int need(input bit p, input int code);
    return (p || code < 4) ? code : 5 * (code - 3);
  endfunction
  task check_flag(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin mismatches++; $display("unexpected at %0t: exp %h got %h", $time, e, g); end
  endtask
  task check_num(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin mismatches++; $display("unexpected at %0t: exp %h got %h", $time, e, g); end
  endtask
  // One result strobe, in or out of window, then the flag latency
  task send(input bit p, input bit out);
    logic [15:0] v;
    rnd = lfsr(rnd);
    v = !out ? 16'h1000 + rnd[15:0] % 16'hd001 : rnd[16] ? rnd[15:0] % 16'h1000 : 16'he001 + rnd[15:0] % 16'h1fff;
    // Corner values on and just beyond each threshold
    if (rnd[19:17] == 3'h0) v = out ? (rnd[16] ? low_thr - 16'h0001 : high_thr + 16'h0001) : (rnd[16] ? low_thr : high_thr);
    @(negedge core_clk);
    if (p) prox_count = v; else light_ch0_count = v;
    prox_result_valid = p;
    light_result_valid = !p;
    @(negedge core_clk);
    prox_result_valid = 1'b0;
    light_result_valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  // Run short of the count, break it, run again, then complete it
  task run_filter(input bit p, input int code, input logic mask);
    int n;
    n = need(p, code);
    host_model_i.write_reg(8'h0C, p ? code << 4 : code);
    prox_irq_mask = mask;
    light_irq_mask = mask;
    // In-window result first: an earlier run leaves the counter part-way
    send(p, 1'b0);
    irq_clear = 1'b1;
    @(negedge core_clk);
    irq_clear = 1'b0;
    if (n == 0) send(p, 1'b0);
    else begin
      repeat (n - 1) send(p, 1'b1);
      send(p, 1'b0);
      repeat (n - 1) send(p, 1'b1);
      check_flag(1'b0, p ? prox_irq : light_irq);
      send(p, 1'b1);
    end
    check_flag(mask, p ? prox_irq : light_irq);
    check_flag(mask, irq_out);
    check_flag(1'b0, p ? light_irq : prox_irq);
    $display("filter test p=%0d code=%0d done", p, code);
  endtask
  // One full sequencer round: integration, pulse train, wait
  task run_seq(input logic lw);
    int li, ep, wt, ld, i;
    logic [7:0] pulses;
    bit seen, pseen;
    li = 0; ep = 0; wt = 0; ld = 0; seen = 0; pseen = 0;
    rnd = lfsr(rnd);
    pulses = rnd[4:0] + 8'h01;
    host_model_i.write_reg(8'h0E, pulses);
    host_model_i.write_reg(8'h0D, {6'h00, lw, 1'b0});
    light_enable = lw;
    power_on = 1'b1;
    for (i = 0; i < 6000; i++) begin
      @(posedge core_clk);
      #1;
      li += light_integrating;
      ep += emitter_pulse;
      wt += waiting;
      pseen |= prox_cycle_active;
      ld += !pseen;
      if (seen && !waiting) break;
      seen |= waiting;
    end
    if (i == 6000) begin mismatches++; close_out(); end
    @(negedge core_clk);
    power_on = 1'b0;
    check_num(lw ? 16'd20 : 16'd0, li);
    check_num(16'd20, ld);
    check_num(pulses, ep);
    check_num(lw ? 16'd120 : 16'd10, wt);
    $display("sequencer test long=%0d done", lw);
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1; power_on = 0; light_enable = 0; prox_enable = 1; wait_enable = 1; irq_clear = 0;
    prox_irq_mask = 0; light_irq_mask = 0; light_result_valid = 0; prox_result_valid = 0;
    light_integration_setting = 8'hfe; wait_period_setting = 8'hff; light_ch0_count = 0; prox_count = 0;
    low_thr = 16'h1000; high_thr = 16'he000; mismatches = 0; comparisons = 0; rnd = 32'h9ebf_0a27;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    // Reset values, unmapped offset last
    for (int a = 12; a < 16; a++) begin
      host_model_i.read_reg(a, rd);
      check_num(a == 14 ? 16'h0001 : 16'h0000, {8'h00, rd});
    end
    rnd = lfsr(rnd);
    host_model_i.write_reg(8'h0D, rnd[7:0]);
    host_model_i.read_reg(8'h0D, rd);
    check_num({8'h00, rnd[7:0] & 8'h02}, {8'h00, rd});
    $display("register test done");
    for (int c = 0; c < 16; c++) begin
      run_filter(1'b0, c, 1'b1);
      run_filter(1'b1, c, 1'b1);
    end
    run_filter(1'b0, 0, 1'b0);
    run_filter(1'b1, 3, 1'b0);
    run_seq(1'b0);
    run_seq(1'b1);
    close_out();
  end
endmodule // testbench
